// *** hdl/csr_pkg.sv ***
/*
 * Shared constants and carrier types for the core special-register block.
 * Assumes one clock domain and a 32-bit AXI4-Lite register bus.
 */
package csr_pkg;

  // ---------------------------------------------------------------
  // Special-register indices (bus byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADR_STACK_POINTER = 8'h81;
  localparam logic [7:0] ADR_DP0_LOW       = 8'h82;
  localparam logic [7:0] ADR_DP0_HIGH      = 8'h83;
  localparam logic [7:0] ADR_DP1_LOW       = 8'h84;
  localparam logic [7:0] ADR_DP1_HIGH      = 8'h85;
  localparam logic [7:0] ADR_CYCLE_CTRL    = 8'h8E;
  localparam logic [7:0] ADR_POINTER_SEL   = 8'h92;
  localparam logic [7:0] ADR_STATUS_WORD   = 8'hD0;
  localparam logic [7:0] ADR_OPERAND       = 8'hE0;
  localparam logic [7:0] ADR_MULDIV_AUX    = 8'hF0;
  // Window onto internal scratch RAM: byte index = (addr - base) / 4
  localparam logic [11:0] ADR_INTERNAL_SCRATCH_RAM_BASE    = 12'h400;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_STACK_POINTER = 8'h07;
  localparam logic [7:0] RST_ZERO          = 8'h00;
  localparam logic [7:0] RST_CYCLE_CTRL    = 8'h01;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int PSW_CARRY      = 7;
  localparam int PSW_HALF_CARRY = 6;
  localparam int PSW_USER0      = 5;
  localparam int PSW_BANK_HI    = 4;
  localparam int PSW_BANK_LO    = 3;
  localparam int PSW_SIGNED_OV  = 2;
  localparam int PSW_USER1      = 1;
  localparam int PSW_PARITY     = 0;
  localparam int SEL_BIT        = 0;
  localparam logic [7:0] CYC_WRITE_MASK = 8'h77;

  // ---------------------------------------------------------------
  // Memory map
  // ---------------------------------------------------------------
  localparam int          INTERNAL_SCRATCH_RAM_DEPTH     = 256;
  localparam logic [7:0]  INTERNAL_SCRATCH_RAM_UPPER     = 8'h80;
  localparam logic [15:0] XRAM_FIRST     = 16'h8000;
  localparam logic [15:0] XRAM_LAST      = 16'h87FF;

  // ---------------------------------------------------------------
  // Bus answer codes
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Execution-side update request from the core pipeline
  typedef struct packed {
    logic       acc_we;
    logic [7:0] acc_d;
    logic       aux_we;
    logic [7:0] aux_d;
    logic       flags_we;
    logic       carry_d;
    logic       half_carry_d;
    logic       signed_ov_d;
    logic       push;
    logic       pop;
  } csr_exec_t;

  // Internal RAM access from the core pipeline
  typedef struct packed {
    logic       req;
    logic       we;
    logic       indirect;
    logic       bank_rel;
    logic [7:0] addr;
    logic [7:0] wdata;
  } csr_internal_scratch_ram_req_t;

endpackage

// *** hdl/csr_core_regs.sv ***
/*
 * Core special registers: operand, aux, status word, stack pointer,
 * two data pointers with selector, cycle control and internal RAM.
 * Assumes the core pipeline drives exec/internal_scratch_ram requests in the aclk domain
 * and software reaches the registers over AXI4-Lite.
 */
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/10ps

module csr_core_regs (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [11:0]            s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [11:0]            s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire csr_pkg::csr_exec_t     exec,
  input  wire csr_pkg::csr_internal_scratch_ram_req_t internal_scratch_ram_req,
  output logic [7:0]                  internal_scratch_ram_rdata,
  output logic [7:0]                  operand_q,
  output logic [7:0]                  status_q,
  output logic [7:0]                  stack_pointer_q,
  output logic [15:0]                 active_data_pointer,
  output logic                        xram_hit,
  output logic [2:0]                  prog_wait_states,
  output logic [2:0]                  external_data_space_stretch
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [7:0]  acc_r;
  logic [7:0]  aux_r;
  logic [7:0]  psw_r;
  logic [7:0]  sp_r;
  logic [15:0] dp0_r;
  logic [15:0] dp1_r;
  logic        sel_r;
  logic [7:0]  cyc_r;
  logic [7:0]  internal_scratch_ram_r [csr_pkg::INTERNAL_SCRATCH_RAM_DEPTH];
  logic [7:0]  internal_scratch_ram_rdata_r;

  // ---------------------------------------------------------------
  // Bus slave state
  // ---------------------------------------------------------------
  logic        aw_held_r;
  logic        w_held_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic        wstrb0_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;

  function automatic logic [8:0] dec_reg(input logic [11:0] a);
    // Returns {hit, register index}; byte address is four times the index
    logic ok;
    ok = (a[1:0] == 2'h0) && (a[11:10] == 2'h0);
    case (a[9:2])
      csr_pkg::ADR_STACK_POINTER, csr_pkg::ADR_DP0_LOW, csr_pkg::ADR_DP0_HIGH,
      csr_pkg::ADR_DP1_LOW, csr_pkg::ADR_DP1_HIGH, csr_pkg::ADR_CYCLE_CTRL,
      csr_pkg::ADR_POINTER_SEL, csr_pkg::ADR_STATUS_WORD, csr_pkg::ADR_OPERAND,
      csr_pkg::ADR_MULDIV_AUX: dec_reg = {ok, a[9:2]};
      default: dec_reg = {1'b0, a[9:2]};
    endcase
  endfunction

  function automatic logic dec_internal_scratch_ram(input logic [11:0] a);
    dec_internal_scratch_ram = (a[11:10] == csr_pkg::ADR_INTERNAL_SCRATCH_RAM_BASE[11:10]) && (a[1:0] == 2'h0);
  endfunction

  // ---------------------------------------------------------------
  // Write channel decode
  // ---------------------------------------------------------------
  wire         aw_take   = s_axi_awvalid && s_axi_awready;
  wire         w_take    = s_axi_wvalid && s_axi_wready;
  wire         aw_have   = aw_held_r || aw_take;
  wire         w_have    = w_held_r || w_take;
  wire         wr_go     = aw_have && w_have && !bvalid_r;
  wire  [11:0] wr_addr   = aw_held_r ? awaddr_r : s_axi_awaddr;
  wire  [7:0]  wr_byte   = w_held_r ? wdata_r[7:0] : s_axi_wdata[7:0];
  wire         wr_lane0  = w_held_r ? wstrb0_r : s_axi_wstrb[0];
  wire  [8:0]  wr_dec    = dec_reg(wr_addr);
  wire         wr_internal_scratch_ram   = dec_internal_scratch_ram(wr_addr);
  wire         wr_hit    = wr_dec[8] || wr_internal_scratch_ram;
  wire         wr_en     = wr_go && wr_dec[8] && wr_lane0;
  wire  [7:0]  wr_reg    = wr_dec[7:0];
  wire  [7:0]  wr_iidx   = wr_addr[9:2];

  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready  = !w_held_r && !bvalid_r;

  // Address capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awaddr_r  <= 12'h000;
    end else begin
      aw_held_r <= aw_have && !wr_go;
      if (aw_take) awaddr_r <= s_axi_awaddr;
    end
  end

  // Data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wdata_r  <= 32'h00000000;
      wstrb0_r <= 1'b0;
    end else begin
      w_held_r <= w_have && !wr_go;
      if (w_take) begin
        wdata_r  <= s_axi_wdata;
        wstrb0_r <= s_axi_wstrb[0];
      end
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= csr_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_hit ? csr_pkg::RESP_OKAY : csr_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;

  // ---------------------------------------------------------------
  // Software write strobes
  // ---------------------------------------------------------------
  wire sw_acc  = wr_en && (wr_reg == csr_pkg::ADR_OPERAND);
  wire sw_aux  = wr_en && (wr_reg == csr_pkg::ADR_MULDIV_AUX);
  wire sw_psw  = wr_en && (wr_reg == csr_pkg::ADR_STATUS_WORD);
  wire sw_sp   = wr_en && (wr_reg == csr_pkg::ADR_STACK_POINTER);
  wire sw_d0l  = wr_en && (wr_reg == csr_pkg::ADR_DP0_LOW);
  wire sw_d0h  = wr_en && (wr_reg == csr_pkg::ADR_DP0_HIGH);
  wire sw_d1l  = wr_en && (wr_reg == csr_pkg::ADR_DP1_LOW);
  wire sw_d1h  = wr_en && (wr_reg == csr_pkg::ADR_DP1_HIGH);
  wire sw_sel  = wr_en && (wr_reg == csr_pkg::ADR_POINTER_SEL);
  wire sw_cyc  = wr_en && (wr_reg == csr_pkg::ADR_CYCLE_CTRL);
  wire sw_internal_scratch_ram = wr_go && wr_internal_scratch_ram && wr_lane0;

  // ---------------------------------------------------------------
  // Operand and aux registers
  // ---------------------------------------------------------------
  // Operand register update
  wire [7:0] acc_nxt = exec.acc_we ? exec.acc_d : (sw_acc ? wr_byte : acc_r);
  wire [7:0] aux_nxt = exec.aux_we ? exec.aux_d : (sw_aux ? wr_byte : aux_r);

  // ---------------------------------------------------------------
  // Status word
  // ---------------------------------------------------------------
  logic [7:0] psw_base;
  logic [7:0] psw_nxt;
  always_comb begin
    // Software owns user flags and bank field
    psw_base = sw_psw ? wr_byte : psw_r;
    psw_nxt  = psw_base;
    if (exec.flags_we) begin
      psw_nxt[csr_pkg::PSW_CARRY]      = exec.carry_d;
      psw_nxt[csr_pkg::PSW_HALF_CARRY] = exec.half_carry_d;
      psw_nxt[csr_pkg::PSW_SIGNED_OV]  = exec.signed_ov_d;
    end
    psw_nxt[csr_pkg::PSW_PARITY] = ^acc_nxt;
  end

  // ---------------------------------------------------------------
  // Stack pointer, data pointers, selector, cycle control
  // ---------------------------------------------------------------
  logic [7:0] sp_nxt;
  always_comb begin
    if (exec.push && !exec.pop) begin
      sp_nxt = sp_r + 8'h01;
    end else if (exec.pop && !exec.push) begin
      sp_nxt = sp_r - 8'h01;
    end else if (sw_sp && !exec.push && !exec.pop) begin
      sp_nxt = wr_byte;
    end else begin
      sp_nxt = sp_r;
    end
  end

  wire [15:0] dp0_nxt = {sw_d0h ? wr_byte : dp0_r[15:8], sw_d0l ? wr_byte : dp0_r[7:0]};
  wire [15:0] dp1_nxt = {sw_d1h ? wr_byte : dp1_r[15:8], sw_d1l ? wr_byte : dp1_r[7:0]};
  wire        sel_nxt = sw_sel ? wr_byte[csr_pkg::SEL_BIT] : sel_r;
  // Unused bits 7 and 3 stay zero
  wire [7:0]  cyc_nxt = sw_cyc ? (wr_byte & csr_pkg::CYC_WRITE_MASK) : cyc_r;

  // Operand, aux and status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_r <= csr_pkg::RST_ZERO;
      aux_r <= csr_pkg::RST_ZERO;
      psw_r <= csr_pkg::RST_ZERO;
    end else begin
      acc_r <= acc_nxt;
      aux_r <= aux_nxt;
      psw_r <= psw_nxt;
    end
  end

  // Stack pointer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sp_r <= csr_pkg::RST_STACK_POINTER;
    end else begin
      sp_r <= sp_nxt;
    end
  end

  // Data pointers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dp0_r <= {csr_pkg::RST_ZERO, csr_pkg::RST_ZERO};
      dp1_r <= {csr_pkg::RST_ZERO, csr_pkg::RST_ZERO};
    end else begin
      dp0_r <= dp0_nxt;
      dp1_r <= dp1_nxt;
    end
  end

  // Selector and cycle control
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_r <= 1'b0;
      cyc_r <= csr_pkg::RST_CYCLE_CTRL;
    end else begin
      sel_r <= sel_nxt;
      cyc_r <= cyc_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Internal scratch RAM
  // ---------------------------------------------------------------
  // Bank offset added to index
  wire [7:0] bank_base = {3'h0, psw_r[csr_pkg::PSW_BANK_HI:csr_pkg::PSW_BANK_LO], 3'h0};
  wire [7:0] core_idx  = internal_scratch_ram_req.bank_rel ? (bank_base + {5'h00, internal_scratch_ram_req.addr[2:0]})
                                           : internal_scratch_ram_req.addr;
  // Direct upper half goes to special registers
  wire       core_ok   = internal_scratch_ram_req.req &&
                         (internal_scratch_ram_req.bank_rel || internal_scratch_ram_req.indirect ||
                          core_idx < csr_pkg::INTERNAL_SCRATCH_RAM_UPPER);
  wire       core_wr   = core_ok && internal_scratch_ram_req.we;
  wire [7:0] rd_sel    = s_axi_araddr[9:2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      internal_scratch_ram_rdata_r <= 8'h00;
    end else if (core_ok && !internal_scratch_ram_req.we) begin
      internal_scratch_ram_rdata_r <= internal_scratch_ram_r[core_idx];
    end else if (internal_scratch_ram_req.req) begin
      // Unserved access reads as zero
      internal_scratch_ram_rdata_r <= 8'h00;
    end
  end

  // Core write wins over a software write to the same byte
  always_ff @(posedge aclk) begin
    if (core_wr) begin
      internal_scratch_ram_r[core_idx] <= internal_scratch_ram_req.wdata;
    end
    if (sw_internal_scratch_ram && !(core_wr && core_idx == wr_iidx)) begin
      internal_scratch_ram_r[wr_iidx] <= wr_byte;
    end
  end

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  wire [8:0] rd_dec = dec_reg(s_axi_araddr);
  wire       rd_ir  = dec_internal_scratch_ram(s_axi_araddr);
  logic [7:0] rd_byte;
  always_comb begin
    case (rd_dec[7:0])
      csr_pkg::ADR_STACK_POINTER: rd_byte = sp_r;
      csr_pkg::ADR_DP0_LOW:       rd_byte = dp0_r[7:0];
      csr_pkg::ADR_DP0_HIGH:      rd_byte = dp0_r[15:8];
      csr_pkg::ADR_DP1_LOW:       rd_byte = dp1_r[7:0];
      csr_pkg::ADR_DP1_HIGH:      rd_byte = dp1_r[15:8];
      csr_pkg::ADR_CYCLE_CTRL:    rd_byte = cyc_r;
      csr_pkg::ADR_POINTER_SEL:   rd_byte = {7'h00, sel_r};
      csr_pkg::ADR_STATUS_WORD:   rd_byte = psw_r;
      csr_pkg::ADR_OPERAND:       rd_byte = acc_r;
      csr_pkg::ADR_MULDIV_AUX:    rd_byte = aux_r;
      default:                    rd_byte = 8'h00;
    endcase
    if (rd_ir) rd_byte = internal_scratch_ram_r[rd_sel];
  end

  assign s_axi_arready = !rvalid_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h00000000;
      rresp_r  <= csr_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rdata_r  <= (rd_dec[8] || rd_ir) ? {24'h000000, rd_byte} : 32'h00000000;
      rresp_r  <= (rd_dec[8] || rd_ir) ? csr_pkg::RESP_OKAY : csr_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;

  // ---------------------------------------------------------------
  // Outputs to the core
  // ---------------------------------------------------------------
  // Active pointer selection
  assign active_data_pointer = sel_r ? dp1_r : dp0_r;
  assign xram_hit = (active_data_pointer >= csr_pkg::XRAM_FIRST) &&
                    (active_data_pointer <= csr_pkg::XRAM_LAST);
  assign prog_wait_states = cyc_r[6:4];
  assign external_data_space_stretch    = cyc_r[2:0];
  assign operand_q        = acc_r;
  assign status_q         = psw_r;
  assign stack_pointer_q  = sp_r;
  assign internal_scratch_ram_rdata       = internal_scratch_ram_rdata_r;

endmodule

// *** dv/csr_core_regs_monitor.sv ***
/*
 * Checker for the core special-register block.
 * Assumes it is bound to csr_core_regs and sees only its ports.
 */
`timescale 1ns/10ps
module csr_core_regs_monitor (
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wready,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic               s_axi_rvalid,
  input wire csr_pkg::csr_exec_t exec,
  input wire logic [7:0]         operand_q,
  input wire logic [7:0]         status_q,
  input wire logic [7:0]         stack_pointer_q,
  input wire logic [15:0]        active_data_pointer,
  input wire logic               xram_hit,
  input wire logic [2:0]         prog_wait_states,
  input wire logic [2:0]         external_data_space_stretch
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_parity_track: assert property (status_q[0] == ^operand_q)
    else $error("parity flag differs from operand parity");
  a_acc_load: assert property (exec.acc_we |=> operand_q == $past(exec.acc_d))
    else $error("operand register missed core write");
  a_flags_load: assert property (exec.flags_we |=> status_q[7] == $past(exec.carry_d)
    && status_q[6] == $past(exec.half_carry_d) && status_q[2] == $past(exec.signed_ov_d))
    else $error("status flags missed core update");
  a_push_incr: assert property (exec.push && !exec.pop
    |=> stack_pointer_q == $past(stack_pointer_q) + 8'h01)
    else $error("stack pointer not incremented on push");
  a_pop_decr: assert property (exec.pop && !exec.push
    |=> stack_pointer_q == $past(stack_pointer_q) - 8'h01)
    else $error("stack pointer not decremented on pop");
  a_reset_values: assert property ($rose(aresetn) |-> stack_pointer_q == 8'h07
    && external_data_space_stretch == 3'h1 && prog_wait_states == 3'h0 && status_q == 8'h00)
    else $error("wrong value after reset");
  a_xram_range: assert property (xram_hit == (active_data_pointer >= 16'h8000
    && active_data_pointer <= 16'h87FF))
    else $error("external RAM decode wrong");
  a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##0
    !s_axi_arready)
    else $error("read answer missing");
  a_bresp_taken: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
endmodule

bind csr_core_regs csr_core_regs_monitor u_monitor (.*);

// *** dv/testbench.sv ***
/*
 * Self-checking bench for the core special-register block.
 * Assumes registers sit at byte address four times their index.
 */
`timescale 1ns/10ps
module testbench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, xram_hit;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  csr_pkg::csr_exec_t exec = '0;
  csr_pkg::csr_internal_scratch_ram_req_t internal_scratch_ram_req = '0;
  logic [7:0] internal_scratch_ram_rdata, operand_q, status_q, stack_pointer_q, q;
  logic [15:0] active_data_pointer;
  logic [2:0] prog_wait_states, external_data_space_stretch;
  int mismatches = 0;
  int checked = 0;
  logic [7:0] adr [10] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h8E, 8'h92, 8'hD0, 8'hE0, 8'hF0};
  logic [7:0] rst [10] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] wv [10] = '{8'h5A, 8'hFF, 8'h87, 8'h00, 8'h88, 8'h01, 8'h01, 8'h3A, 8'h07, 8'hC3};

  csr_core_regs u_dut (.*);

  always #50 aclk = ~aclk;

  function automatic logic [11:0] ra(input logic [7:0] i);
    return {2'h0, i, 2'h0};
  endfunction

  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic print_verdict;
    if (mismatches == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic hang(input logic ok);
    if (!ok) begin
      cmp("timeout", 32'h0, 32'h1);
      print_verdict;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    logic aw, w, b;
    logic [1:0] r;
    n = 0;
    b = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!b && n < 50) begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      n++;
    end
    hang(b);
    cmp("bresp", {30'h0, er}, {30'h0, r});
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
    int n;
    logic ar, v;
    logic [31:0] d;
    logic [1:0] r;
    n = 0;
    v = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!v && n < 50) begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      v = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
      n++;
    end
    hang(v);
    cmp($sformatf("rdata %h", a), {24'h0, e}, d);
    cmp("rresp", {30'h0, er}, {30'h0, r});
  endtask

  task automatic ex(input csr_pkg::csr_exec_t e);
    exec <= e;
    @(posedge aclk);
    exec <= '0;
    @(posedge aclk);
  endtask

  task automatic ir(input logic w, input logic ind, input logic bk, input logic [7:0] a,
                    input logic [7:0] d);
    internal_scratch_ram_req <= '{req: 1'b1, we: w, indirect: ind, bank_rel: bk, addr: a, wdata: d};
    @(posedge aclk);
    internal_scratch_ram_req <= '0;
    @(negedge aclk);
    q = internal_scratch_ram_rdata;
    @(posedge aclk);
  endtask

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    s_axi_bready <= 1'b1;
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 10; i++) rd(ra(adr[i]), rst[i], csr_pkg::RESP_OKAY);
    for (int i = 0; i < 10; i++) begin
      wr(ra(adr[i]), wv[i], csr_pkg::RESP_OKAY);
      rd(ra(adr[i]), wv[i], csr_pkg::RESP_OKAY);
    end
    cmp("stretch", 32'h1, {29'h0, external_data_space_stretch});
    cmp("waits", 32'h0, {29'h0, prog_wait_states});
    cmp("pointer", 32'h8800, {16'h0, active_data_pointer});
    cmp("xram", 32'h0, {31'h0, xram_hit});
    wr(ra(8'h92), 8'h00, csr_pkg::RESP_OKAY);
    cmp("pointer", 32'h87FF, {16'h0, active_data_pointer});
    cmp("xram", 32'h1, {31'h0, xram_hit});
    rd(ra(8'hD0), 8'h3B, csr_pkg::RESP_OKAY);
    wr(ra(8'hD0), 8'h00, csr_pkg::RESP_OKAY);
    rd(ra(8'hD0), 8'h01, csr_pkg::RESP_OKAY);
    ex('{acc_we: 1'b1, acc_d: 8'h06, default: '0});
    cmp("status", 32'h0, {24'h0, status_q});
    cmp("operand", 32'h06, {24'h0, operand_q});
    ex('{flags_we: 1'b1, carry_d: 1'b1, half_carry_d: 1'b1, signed_ov_d: 1'b1, default: '0});
    cmp("status", 32'hC4, {24'h0, status_q});
    ex('{aux_we: 1'b1, aux_d: 8'h9C, default: '0});
    rd(ra(8'hF0), 8'h9C, csr_pkg::RESP_OKAY);
    ex('{push: 1'b1, default: '0});
    ex('{push: 1'b1, default: '0});
    ex('{pop: 1'b1, default: '0});
    ex('{push: 1'b1, pop: 1'b1, default: '0});
    cmp("stack", 32'h5B, {24'h0, stack_pointer_q});
    wr(ra(8'hD0), 8'h18, csr_pkg::RESP_OKAY);
    ir(1'b1, 1'b0, 1'b1, 8'h02, 8'h3C);
    ir(1'b0, 1'b0, 1'b0, 8'h1A, 8'h00);
    cmp("bank", 32'h3C, {24'h0, q});
    ir(1'b1, 1'b1, 1'b0, 8'h90, 8'h77);
    ir(1'b0, 1'b1, 1'b0, 8'h90, 8'h00);
    cmp("upper", 32'h77, {24'h0, q});
    ir(1'b0, 1'b0, 1'b0, 8'h90, 8'h00);
    cmp("direct", 32'h0, {24'h0, q});
    rd(12'h640, 8'h77, csr_pkg::RESP_OKAY);
    rd(12'h008, 8'h00, csr_pkg::RESP_SLVERR);
    wr(12'h008, 8'h55, csr_pkg::RESP_SLVERR);
    print_verdict;
  end
endmodule
